//--- bench/test_radio_coex_arbitration_client.sv
// self-checking bench for the radio arbitration client
// assumes the arbiter model on the far side of the grant pin
`timescale 1ns/1ns
module test_radio_coex_arbitration_client;
    import coex_pkg::*;
    localparam int MSC = 20;
    localparam int PCC = 2;
    logic sys_clk = 0, rst_n = 0, ce = 1, psel = 0, penable = 0;
    logic pwrite = 0, busy = 0, slow = 0, holdoff = 0, err;
    logic tx_pending = 0, tx_active = 0, rx_sync = 0, rx_addr = 0;
    logic rx_done = 0, cca_fail = 0, mac_fail = 0, tx_ok = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, rdat, rnd;
    logic pready, pslverr, deny, req, prio, mac_go, ack, tx_abort;
    logic [7:0] pcode [4] = '{8'h00, 8'h80, 8'h82, 8'h81};
    int pduty [4] = '{5, 4, 96, 50};
    int num_errors = 0, total_checks = 0, seed = 32'hFEE6, n, m, e, i;
    coex_arbitration_client #(.MS_CYC(MSC), .PCT_CYC(PCC))
        i_coex_arbitration_client (.sys_clk(sys_clk), .rst_n(rst_n),
        .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .arbiter_deny(deny),
        .radio_holdoff_in(holdoff), .tx_pending(tx_pending),
        .tx_active(tx_active), .rx_sync_det(rx_sync),
        .rx_addr_det(rx_addr), .rx_done(rx_done), .cca_fail(cca_fail),
        .mac_fail(mac_fail), .tx_ok(tx_ok), .radio_active_req(req),
        .radio_status_prio(prio), .mac_go(mac_go),
        .ack_allowed(ack), .tx_abort(tx_abort));
    wlan_arbiter_model i_wlan_arbiter_model (.sys_clk(sys_clk),
        .rst_n(rst_n), .busy(busy), .slow(slow), .arbiter_deny(deny));
    // ****************
    // tasks
    // ****************
    task automatic step(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    task automatic fail_msg(input string s);
        num_errors++;
        $display("CHECK FAILED %0t %s", $time, s);
    endtask
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x)
            fail_msg($sformatf("reg %h exp %h", g, x));
    endtask
    task automatic chk_pin(input logic g, input logic x);
        total_checks++;
        if (g !== x)
            fail_msg($sformatf("pin %b exp %b", g, x));
    endtask
    task automatic chk_cnt(input int g, input int x);
        total_checks++;
        if (g != x)
            fail_msg($sformatf("count %0d exp %0d", g, x));
    endtask
    // one idle edge first so no strobe is driven twice in a time step
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no local limit: the watchdog ends a hung access
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h00000000);
        chk_reg(rdat, x);
    endtask
    task automatic complete_run;
        if (num_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        step(20000);
        fail_msg("timeout");
        complete_run();
    end
    // ****************
    // scenarios
    // ****************
    initial
    begin
        step(8);
        rst_n <= 1'b1;
        rd(OFF_CTRL, 32'h00000001);
        rd(OFF_OPT, 32'h00003C10);
        rd(OFF_PWM, 32'h00143200);
        rd(OFF_DIRW, 32'h00000000);
        rd(8'h14, 32'h00000000);
        chk_pin(err, 1'b1);
        // software keeps the reserved option bits at zero
        rnd = $random(seed) & 32'h067F7FFF;
        wr(OFF_OPT, rnd);
        rd(OFF_OPT, rnd);
        for (i = 0; i < 4; i++)
        begin
            wr(OFF_OPT, {20'h00000, i[1:0], 10'h000});
            tx_pending <= 1'b1;
            step(3);
            chk_pin(req, 1'b1);
            chk_pin(prio, i[0]);
            tx_pending <= 1'b0;
            rx_sync <= 1'b1;
            step(3);
            chk_pin(prio, i[1]);
            rx_sync <= 1'b0;
        end
        wr(OFF_OPT, 32'h00040000);
        rx_sync <= 1'b1;
        step(3);
        chk_pin(req, 1'b0);
        rx_addr <= 1'b1;
        step(3);
        chk_pin(req, 1'b1);
        rx_sync <= 1'b0;
        rx_addr <= 1'b0;
        wr(OFF_OPT, 32'h00010400);
        tx_pending <= 1'b1;
        step(3);
        chk_pin(req, 1'b0);
        wr(OFF_OPT, 32'h00000200);
        wr(OFF_CTRL, 32'h00000000);
        step(2);
        chk_pin(req, 1'b0);
        rd(OFF_CTRL, 32'h00000000);
        wr(OFF_CTRL, 32'h00000001);
        tx_active <= 1'b1;
        for (i = 0; i < 2; i++)
        begin
            slow <= i[0];
            busy <= 1'b1;
            n = 0;
            repeat (12)
            begin
                @(posedge sys_clk);
                n += int'(tx_abort === 1'b1);
            end
            chk_cnt(n, 1);
            busy <= 1'b0;
            step(8);
        end
        tx_active <= 1'b0;
        wr(OFF_CTRL, 32'h00000003);
        for (i = 0; i < 8; i++)
        begin
            wr(OFF_OPT, {14'h0000, 3'h4, i[2], 5'h00, 1'b1, 8'h00});
            busy <= i[0];
            holdoff <= i[1];
            step(8);
            chk_pin(mac_go, !(i[0] | (i[1] & i[2])));
            chk_pin(ack, !(i[0] | (i[1] & i[2])));
        end
        busy <= 1'b0;
        holdoff <= 1'b0;
        wr(OFF_CTRL, 32'h00000001);
        wr(OFF_OPT, 32'h02200000);
        for (i = 0; i < 5; i++)
        begin
            cca_fail <= (i < 2);
            tx_ok <= (i == 2 || i == 4);
            mac_fail <= (i == 3);
            step(1);
            cca_fail <= 1'b0;
            tx_ok <= 1'b0;
            mac_fail <= 1'b0;
            step(3);
            chk_pin(prio, i[0]);
        end
        tx_pending <= 1'b0;
        wr(OFF_OPT, 32'h00003002);
        rx_done <= 1'b1;
        step(1);
        rx_done <= 1'b0;
        step(30);
        chk_pin(req, 1'b1);
        chk_pin(prio, 1'b1);
        step(20);
        chk_pin(req, 1'b0);
        wr(OFF_OPT, 32'h00000000);
        for (i = 1; i >= 0; i--)
        begin
            wr(OFF_DIRW, 32'(i));
            tx_pending <= 1'b1;
            n = 0;
            repeat (200)
            begin
                @(posedge sys_clk);
                n += int'(prio === 1'b1);
            end
            chk_cnt(n, i * US_CYC);
            tx_pending <= 1'b0;
            step(4);
        end
        // ce low must freeze the request flop
        ce <= 1'b0;
        tx_pending <= 1'b1;
        step(3);
        chk_pin(req, 1'b0);
        ce <= 1'b1;
        step(2);
        chk_pin(req, 1'b1);
        tx_pending <= 1'b0;
        step(4);
        for (i = 0; i < 4; i++)
        begin
            wr(OFF_PWM, {8'h00, 8'h0A, pduty[i][7:0], pcode[i]});
            e = pduty[i] < 5 ? 5 : (pduty[i] > 95 ? 95 : pduty[i]);
            if (pcode[i] != PWM_CODE_LO && pcode[i] != PWM_CODE_HI)
                e = 0;
            step(20);
            n = 0;
            m = 0;
            repeat (2000)
            begin
                @(posedge sys_clk);
                n += int'(req === 1'b1);
                m += int'(prio === 1'b1);
            end
            chk_cnt(n, e * 10 * PCC);
            chk_cnt(m, pcode[i] == PWM_CODE_HI ? n : 0);
        end
        complete_run();
    end
endmodule

//--- bench/wlan_arbiter_model.sv
// far-side arbiter model: denies the medium while it is busy
// assumes busy and slow come from the bench on sys_clk
`timescale 1ns/1ns
module wlan_arbiter_model
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic busy,
    input wire logic slow,
    output logic arbiter_deny
);
    logic [3:0] busy_r;
    logic [3:0] busy_nxt;
    assign busy_nxt = {busy_r[2:0], busy};
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            busy_r <= 4'h0;
        else
            busy_r <= busy_nxt;
    end
    // deny high refuses the medium, so grant reads active low
    // slow answer lags four cycles to stress the abort path
    assign arbiter_deny = slow ? busy_r[3] : busy_r[0];
endmodule

//--- common/coex_if.sv
// signals between the arbitration client and its pwm and pulse helpers
// all members are synchronous to sys_clk of the client
`timescale 1ns/1ns
interface coex_if;
    logic ce;
    logic [7:0] pwm_ctl;
    logic [7:0] pwm_duty;
    logic [7:0] pwm_period;
    logic pwm_req;
    logic pwm_hi;
    logic [7:0] dir_width;
    logic req_rise;
    logic req_on;
    logic dir_hold;
    modport ctl (output ce, pwm_ctl, pwm_duty, pwm_period, dir_width,
        req_rise, req_on, input pwm_req, pwm_hi, dir_hold);
    modport pwm (input ce, pwm_ctl, pwm_duty, pwm_period,
        output pwm_req, pwm_hi);
    modport dir (input ce, dir_width, req_rise, req_on, output dir_hold);
endinterface

//--- common/coex_pkg.sv
// constants shared by the arbitration client and its helpers
// assumes a 100 MHz system clock and an APB register bus
package coex_pkg;
    // ****************
    // timing
    // ****************
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int MS_NS = 1000000;
    localparam int US_CYC = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_CYC_DEF = MS_NS / CLK_PERIOD_NS;
    localparam int PCT_STEPS = 100;
    // one duty step is a hundredth of the period; PCT_CYC_DEF is a hundredth of a half-millisecond unit
    localparam int HALF_MS_NS = 500000;
    localparam int PCT_CYC_DEF = HALF_MS_NS / CLK_PERIOD_NS / PCT_STEPS;
    // ****************
    // register map
    // ****************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_OPT = 8'h04;
    localparam logic [7:0] OFF_PWM = 8'h08;
    localparam logic [7:0] OFF_DIRW = 8'h0C;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam int CTRL_EN = 0;
    localparam int CTRL_SHARED = 1;
    localparam int PWM_CTL_LSB = 0;
    localparam int PWM_DUTY_LSB = 8;
    localparam int PWM_PER_LSB = 16;
    // ****************
    // options word fields
    // ****************
    localparam int OPT_TMO_LSB = 0;
    localparam int OPT_NOACK = 8;
    localparam int OPT_ABORT = 9;
    localparam int OPT_TXHI = 10;
    localparam int OPT_RXHI = 11;
    localparam int OPT_RETRYHI = 12;
    localparam int OPT_RETRY = 13;
    localparam int OPT_HOLDOFF = 14;
    localparam int OPT_NOREQ = 16;
    localparam int OPT_MACSYNC = 17;
    localparam int OPT_RXMODE_LSB = 18;
    localparam int OPT_CCATHR_LSB = 20;
    localparam int OPT_MACTHR_LSB = 25;
    localparam logic [31:0] OPT_WMASK = 32'h067F7FFF;
    // ****************
    // reset values
    // ****************
    localparam logic [31:0] OPT_RST = 32'h00003C10;
    localparam logic EN_RST = 1'b1;
    localparam logic SHARED_RST = 1'b0;
    localparam logic [7:0] PWM_CTL_RST = 8'h00;
    localparam logic [7:0] DUTY_RST = 8'h32;
    localparam logic [7:0] PER_RST = 8'h14;
    localparam logic [7:0] DIRW_RST = 8'h00;
    // ****************
    // pwm request codes and ranges
    // ****************
    localparam logic [7:0] PWM_CODE_OFF = 8'h00;
    localparam logic [7:0] PWM_CODE_LO = 8'h80;
    localparam logic [7:0] PWM_CODE_HI = 8'h82;
    localparam logic [7:0] DUTY_MIN = 8'h05;
    localparam logic [7:0] DUTY_MAX = 8'h5F;
    localparam logic [7:0] PER_MIN = 8'h0A;
    localparam logic [7:0] PER_MAX = 8'hDA;

    typedef enum {PWM_DIS, PWM_LOW, PWM_HIGH} pwm_mode_type;

    function automatic logic [7:0] clamp_u8(input logic [7:0] v,
        input logic [7:0] lo, input logic [7:0] hi);
        clamp_u8 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction
endpackage

//--- rtl/coex_arbitration_client.sv
// radio side of the traffic_arbitration handshake with an APB slave
// assumes synchronous inputs and an APB master on sys_clk
//
// Operation
// - pwm control codes: off, low, high
// - pwm duty five to ninety-five percent
// - pwm period ten to 218 half-ms
// - direction pulse width microseconds, zero off
// - global enable readable, writable while running
// - options bits 0-7 retry timeout ms
// - bit 8 with shared request: no ack without secured grant
// - bit 9 aborts transmit on lost grant
// - bits 10, 11 high priority tx, rx
// - bit 13 holds request after receive
// - bit 12 retry request at high priority
// - bit 14 enables hold-off input
// - bit 16 never asserts request
// - bit 17 channel access waits for grant
// - bits 18-19 choose sync or address start
// - bits 20-22 channel check failure escalation
// - bits 25-26 access failure escalation
// - request active high, grant low via deny
// - direction width zero: priority is a static level
// - reset options follow reference configuration
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module coex_arbitration_client
    import coex_pkg::*;
#(
    parameter int MS_CYC = MS_CYC_DEF,
    parameter int PCT_CYC = PCT_CYC_DEF
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic arbiter_deny,
    input wire logic radio_holdoff_in,
    input wire logic tx_pending,
    input wire logic tx_active,
    input wire logic rx_sync_det,
    input wire logic rx_addr_det,
    input wire logic rx_done,
    input wire logic cca_fail,
    input wire logic mac_fail,
    input wire logic tx_ok,
    output logic radio_active_req,
    output logic radio_status_prio,
    output logic mac_go,
    output logic ack_allowed,
    output logic tx_abort
);
    // ****************
    // registers
    // ****************
    logic en_r;
    logic shared_r;
    logic [31:0] opt_r;
    logic [7:0] pwm_ctl_r;
    logic [7:0] duty_r;
    logic [7:0] per_r;
    logic [7:0] dirw_r;
    logic [7:0] retry_ms_r;
    logic [19:0] ms_cnt_r;
    logic [2:0] cca_cnt_r;
    logic [1:0] mac_cnt_r;
    logic grant_d_r;

    coex_if cif();

    function automatic logic esc_hit(input logic [2:0] cnt,
        input logic [2:0] thr);
        esc_hit = (thr != 3'h0) && (cnt >= thr);
    endfunction

    // ****************
    // apb decode
    // ****************
    wire hit_ctrl = paddr == OFF_CTRL;
    wire hit_opt = paddr == OFF_OPT;
    wire hit_pwm = paddr == OFF_PWM;
    wire hit_dirw = paddr == OFF_DIRW;
    wire hit_stat = paddr == OFF_STAT;
    wire mapped = hit_ctrl | hit_opt | hit_pwm | hit_dirw | hit_stat;
    // one wait state; writes land on the edge that completes the access
    wire acc_first = psel && penable && !pready;
    wire wr_fire = ce && psel && penable && pready && pwrite;

    // ****************
    // arbitration core
    // ****************
    wire grant = !arbiter_deny;
    wire holdoff = opt_r[OPT_HOLDOFF] && radio_holdoff_in;
    wire rx_by_addr = opt_r[OPT_RXMODE_LSB +: 2] != 2'b00;
    wire rx_req = rx_by_addr ? rx_addr_det : rx_sync_det;
    wire [7:0] tmo = opt_r[OPT_TMO_LSB +: 8];
    wire retry_act = retry_ms_r != 8'h00;
    wire retry_load = rx_done && opt_r[OPT_RETRY] && tmo != 8'h00;
    wire ms_end = ms_cnt_r == 20'(MS_CYC - 1);
    wire esc_cca = esc_hit(cca_cnt_r, opt_r[OPT_CCATHR_LSB +: 3]);
    wire esc_mac = esc_hit({1'b0, mac_cnt_r},
        {1'b0, opt_r[OPT_MACTHR_LSB +: 2]});
    wire tx_esc = esc_cca || esc_mac;
    wire want = tx_pending || rx_req || retry_act || cif.pwm_req;
    wire req_nxt = en_r && !opt_r[OPT_NOREQ] && want;
    wire req_rise = req_nxt && !radio_active_req;
    // priority choice follows what is being requested, transmit first
    wire tx_lvl = opt_r[OPT_TXHI] || tx_esc;
    wire rx_lvl = opt_r[OPT_RXHI];
    wire retry_lvl = opt_r[OPT_RETRYHI];
    wire prio_lvl = tx_pending ? tx_lvl : rx_req ? rx_lvl :
        retry_act ? retry_lvl : cif.pwm_hi;
    wire dir_on = (req_rise && dirw_r != 8'h00) || cif.dir_hold;
    // during the pulse priority tells direction; otherwise a static level
    wire prio_nxt = req_nxt && (dir_on ? tx_pending : prio_lvl);
    wire mac_go_nxt = !en_r || !opt_r[OPT_MACSYNC] || (grant && !holdoff);
    wire ack_gate = opt_r[OPT_NOACK] && shared_r;
    wire secured = grant && !holdoff && radio_active_req;
    wire ack_nxt = !en_r || !ack_gate || secured;
    wire abort_nxt = en_r && opt_r[OPT_ABORT] && tx_active && !grant &&
        grant_d_r;
    wire [31:0] stat_word = {19'h00000, mac_cnt_r, cca_cnt_r, mac_go,
        cif.pwm_req, tx_esc, retry_act, holdoff, grant, radio_status_prio,
        radio_active_req};

    logic [31:0] rdata;
    assign rdata = hit_ctrl ? {30'h00000000, shared_r, en_r} :
        hit_opt ? opt_r :
        hit_pwm ? {8'h00, per_r, duty_r, pwm_ctl_r} :
        hit_dirw ? {24'h000000, dirw_r} :
        hit_stat ? stat_word : 32'h00000000;

    assign cif.ce = ce;
    assign cif.pwm_ctl = pwm_ctl_r;
    assign cif.pwm_duty = duty_r;
    assign cif.pwm_period = per_r;
    assign cif.dir_width = dirw_r;
    assign cif.req_rise = req_rise;
    assign cif.req_on = req_nxt;

    pwm_request_gen #(.PCT_CYC(PCT_CYC)) u_pwm (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .bus(cif.pwm)
    );

    dir_pulse_timer u_dir (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .bus(cif.dir)
    );

    // ****************
    // apb slave
    // ****************
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else if (ce)
        begin
            pready <= acc_first;
            pslverr <= acc_first && !mapped;
            if (acc_first && !pwrite)
                prdata <= rdata;
        end
    end

    // reserved option bits are dropped; software is expected to write zero
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            en_r <= EN_RST;
            shared_r <= SHARED_RST;
            opt_r <= OPT_RST;
            pwm_ctl_r <= PWM_CTL_RST;
            duty_r <= DUTY_RST;
            per_r <= PER_RST;
            dirw_r <= DIRW_RST;
        end
        else if (wr_fire)
        begin
            if (hit_ctrl)
            begin
                en_r <= pwdata[CTRL_EN];
                shared_r <= pwdata[CTRL_SHARED];
            end
            if (hit_opt)
                opt_r <= pwdata & OPT_WMASK;
            if (hit_pwm)
            begin
                pwm_ctl_r <= pwdata[PWM_CTL_LSB +: 8];
                duty_r <= pwdata[PWM_DUTY_LSB +: 8];
                per_r <= pwdata[PWM_PER_LSB +: 8];
            end
            if (hit_dirw)
                dirw_r <= pwdata[7:0];
        end
    end

    // ****************
    // retry window timer
    // ****************
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            retry_ms_r <= 8'h00;
            ms_cnt_r <= 20'h00000;
        end
        else if (ce)
        begin
            if (retry_load)
            begin
                retry_ms_r <= tmo;
                ms_cnt_r <= 20'h00000;
            end
            else if (retry_act)
            begin
                ms_cnt_r <= ms_end ? 20'h00000 : ms_cnt_r + 20'h00001;
                if (ms_end)
                    retry_ms_r <= retry_ms_r - 8'h01;
            end
        end
    end

    // ****************
    // escalation counters
    // ****************
    // counters saturate so a long failure run cannot wrap back to low
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || (ce && tx_ok))
        begin
            cca_cnt_r <= 3'h0;
            mac_cnt_r <= 2'h0;
        end
        else if (ce)
        begin
            if (cca_fail && cca_cnt_r != 3'h7)
                cca_cnt_r <= cca_cnt_r + 3'h1;
            if (mac_fail && mac_cnt_r != 2'h3)
                mac_cnt_r <= mac_cnt_r + 2'h1;
        end
    end

    // ****************
    // pin outputs
    // ****************
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            radio_active_req <= 1'b0;
            radio_status_prio <= 1'b0;
            mac_go <= 1'b1;
            ack_allowed <= 1'b1;
            tx_abort <= 1'b0;
            grant_d_r <= 1'b0;
        end
        else if (ce)
        begin
            radio_active_req <= req_nxt;
            radio_status_prio <= prio_nxt;
            mac_go <= mac_go_nxt;
            ack_allowed <= ack_nxt;
            tx_abort <= abort_nxt;
            grant_d_r <= grant;
        end
    end

    // ****************
    // assertions
    // ****************
    AST_NOREQ_FORCED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && opt_r[OPT_NOREQ]) |=> !radio_active_req)
        else $error("request asserted while forced off");
    AST_DISABLED_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && !en_r) |=> (!radio_active_req && mac_go && ack_allowed))
        else $error("disabled client drives the link");
    AST_MAC_WAITS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && en_r && opt_r[OPT_MACSYNC] && arbiter_deny) |=> !mac_go)
        else $error("channel access allowed without grant");
    AST_HOLDOFF_IGNORED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && opt_r[OPT_MACSYNC] && !opt_r[OPT_HOLDOFF] && !arbiter_deny)
        |=> mac_go)
        else $error("hold-off honoured while disabled");
    AST_NO_ACK: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && en_r && opt_r[OPT_NOACK] && shared_r && arbiter_deny)
        |=> !ack_allowed)
        else $error("ack allowed without grant");
    AST_ABORT_CAUSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tx_abort |-> $past(tx_active && arbiter_deny && opt_r[OPT_ABORT]))
        else $error("abort without lost grant");
    AST_TX_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && en_r && tx_pending && opt_r[OPT_TXHI] && !opt_r[OPT_NOREQ]
        && dirw_r == 8'h00) |=> (radio_active_req && radio_status_prio))
        else $error("transmit not at high priority");
    AST_RETRY_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ce && en_r && retry_load && !opt_r[OPT_NOREQ]) ##1 ce
        |=> radio_active_req)
        else $error("retry window did not hold request");
    AST_PRIO_WITH_REQ: assert property (@(posedge sys_clk) disable iff (!rst_n)
        radio_status_prio |-> radio_active_req)
        else $error("priority without request");
    AST_APB_ERR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pslverr |-> (pready && $past(psel && penable && !mapped)))
        else $error("slave error on mapped access");
    COV_ABORT: cover property (@(posedge sys_clk) disable iff (!rst_n)
        tx_abort);
    COV_RETRY: cover property (@(posedge sys_clk) disable iff (!rst_n)
        retry_act && radio_active_req && !rx_req);
    COV_ESCALATE: cover property (@(posedge sys_clk) disable iff (!rst_n)
        tx_esc && tx_pending && radio_status_prio);
endmodule

//--- rtl/dir_pulse_timer.sv
// times the direction pulse on priority at the start of each request
// assumes req_rise is one cycle wide, from the same edge as the request
`timescale 1ns/1ns
module dir_pulse_timer
    import coex_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    coex_if.dir bus
);
    logic [15:0] cnt_r;
    wire [15:0] load = 16'(bus.dir_width) * 16'(US_CYC);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            cnt_r <= 16'h0000;
        else if (bus.ce)
        begin
            if (bus.req_rise)
                cnt_r <= load;
            else if (!bus.req_on || cnt_r == 16'h0000)
                cnt_r <= 16'h0000;
            else
                cnt_r <= cnt_r - 16'h0001;
        end
    end

    // the rise cycle itself is covered by the client, so hold stops at one
    assign bus.dir_hold = cnt_r > 16'h0001;

    AST_DIR_ZERO_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (bus.ce && bus.req_rise && bus.dir_width == 8'h00) |=> !bus.dir_hold)
        else $error("direction pulse with zero width");
endmodule

//--- rtl/pwm_request_gen.sv
// periodic request generator: period in half-ms units, duty in percent
// assumes cfg fields held stable by the register block
`timescale 1ns/1ns
module pwm_request_gen
    import coex_pkg::*;
#(
    parameter int PCT_CYC = PCT_CYC_DEF
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    coex_if.pwm bus
);
    logic [19:0] sub_r;
    logic [7:0] unit_r;
    logic [6:0] pct_r;
    pwm_mode_type mode;
    wire [7:0] duty_c = clamp_u8(bus.pwm_duty, DUTY_MIN, DUTY_MAX);
    wire [7:0] per_c = clamp_u8(bus.pwm_period, PER_MIN, PER_MAX);
    wire sub_end = sub_r == 20'(PCT_CYC - 1);
    wire unit_end = sub_end && (unit_r == per_c - 8'h01);
    wire run = mode != PWM_DIS;

    // undefined codes act as disabled
    always_comb
    begin
        case (bus.pwm_ctl)
            PWM_CODE_LO: mode = PWM_LOW;
            PWM_CODE_HI: mode = PWM_HIGH;
            default: mode = PWM_DIS;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || (bus.ce && !run))
        begin
            sub_r <= 20'h00000;
            unit_r <= 8'h00;
            pct_r <= 7'h00;
            bus.pwm_req <= 1'b0;
            bus.pwm_hi <= 1'b0;
        end
        else if (bus.ce)
        begin
            sub_r <= sub_end ? 20'h00000 : sub_r + 20'h00001;
            if (sub_end)
                unit_r <= unit_end ? 8'h00 : unit_r + 8'h01;
            if (unit_end)
                pct_r <= (pct_r == 7'(PCT_STEPS - 1)) ? 7'h00 : pct_r + 7'h01;
            bus.pwm_req <= {1'b0, pct_r} < duty_c;
            bus.pwm_hi <= mode == PWM_HIGH;
        end
    end

    AST_PWM_UNDEF_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (bus.ce && bus.pwm_ctl != PWM_CODE_LO && bus.pwm_ctl != PWM_CODE_HI)
        |=> !bus.pwm_req)
        else $error("pwm request active on undefined code");
    COV_PWM_HIGH: cover property (@(posedge sys_clk) disable iff (!rst_n)
        bus.pwm_req && bus.pwm_hi);
endmodule
